// file: status_byte_pkg.sv
// Purpose: Constants for the status summary byte block
// Assumes: One system clock, asynchronous active-low reset
// Notes: Bit positions follow the summary byte layout
package status_byte_pkg;

  // ----------------------------------------
  // Summary byte bit positions
  // ----------------------------------------
  localparam int unsigned STB_WIDTH = 8;
  localparam int unsigned BIT_RSVD0 = 0;
  localparam int unsigned BIT_RSVD1 = 1;
  localparam int unsigned BIT_ERRQ = 2;
  localparam int unsigned BIT_QUES = 3;
  localparam int unsigned BIT_MSG_AVAIL = 4;
  localparam int unsigned BIT_EVT_SUM = 5;
  localparam int unsigned BIT_MASTER = 6;
  localparam int unsigned BIT_OPER = 7;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] STB_RESET = 8'h00;
  localparam logic [7:0] SRQ_EN_RESET = 8'h00;
  localparam logic [15:0] EVT_EN_RESET = 16'h0000;
  localparam logic [7:0] STD_EN_RESET = 8'h00;

  // ----------------------------------------
  // Reply path
  // ----------------------------------------
  localparam int unsigned REPLY_LATENCY = 1;

  typedef enum logic [0:0] {
    SRC_POLL,
    SRC_QUERY
  } read_src_t;

endpackage : status_byte_pkg

// file: mask_summary.sv
// Purpose: Masked OR summary of an event register
// Assumes: Event and enable come from the same clock
// Notes: Output registered for clean timing
`timescale 1ns/1ps
module mask_summary #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic [WIDTH-1:0] event_i,
  input wire logic [WIDTH-1:0] enable_i,
  output logic summary_o
);

  logic summary_d;
  logic summary_q;

  // ----------------------------------------
  // OR over all positions of event AND enable
  // ----------------------------------------
  always_comb begin
    summary_d = |(event_i & enable_i); // see RULE_10
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      summary_q <= 1'b0;
    end else begin
      summary_q <= summary_d;
    end
  end

  assign summary_o = summary_q;

endmodule : mask_summary

// file: status_byte_summary.sv
// Purpose: Status summary byte with master summary and read paths
// Assumes: Sources and enables are synchronous to sys_clk_i
// Notes: Reads never modify any status state
//
// Operation
// RULE_01: Bit 2 is high while the error/event queue holds at least one entry.
// RULE_02: Bit 3 is set when any questionable event bit is set with its enable bit.
// RULE_03: Bit 4 is high while the output queue holds response bytes, low when empty.
// RULE_04: Bit 5 carries the summary of the standard event status register.
// RULE_05: Bit 6 reports the master summary, high when any service reason exists.
// RULE_06: Bit 7 is set when a bit is set in the operation status register.
// RULE_07: The byte can be read by serial poll or by status query, both answered.
// RULE_08: A status query returns the byte with the master summary and alters nothing.
// RULE_09: Summary-level registers have only enable masks, no transition filters.
// RULE_10: Every summary is the OR over positions of register bit AND enable bit.
// RULE_11: Master summary is the OR of bits 0 to 5 and 7 ANDed with the service enable.
// RULE_12: Operation summary is true only when an event bit and its enable are set.
// RULE_13: The query reply is the weighted byte value with the master summary in bit 6.
// RULE_14: Reserved bits 0 and 1 read zero and never feed the master summary.
`timescale 1ns/1ps
module status_byte_summary
  import status_byte_pkg::*;
#(
  parameter int unsigned QUES_WIDTH = 16,
  parameter int unsigned OPER_WIDTH = 16,
  parameter int unsigned STD_WIDTH = 8
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic err_queue_nonempty_i,
  input wire logic out_queue_nonempty_i,
  input wire logic [QUES_WIDTH-1:0] ques_event_i,
  input wire logic [QUES_WIDTH-1:0] ques_enable_i,
  input wire logic [OPER_WIDTH-1:0] oper_event_i,
  input wire logic [OPER_WIDTH-1:0] oper_enable_i,
  input wire logic [STD_WIDTH-1:0] std_event_i,
  input wire logic [STD_WIDTH-1:0] std_enable_i,
  input wire logic [7:0] srq_enable_i,
  input wire logic poll_req_i,
  input wire logic query_req_i,
  output logic [7:0] status_summary_byte_o,
  output logic master_summary_o,
  output logic reply_valid_o,
  output logic [7:0] reply_data_o,
  output logic reply_is_query_o
);

  // ----------------------------------------
  // Summaries of lower registers
  // ----------------------------------------
  logic questionable_summary;
  logic operation_summary;
  logic evt_summary;

  // Enable masks only, no transition filters here
  mask_summary #(.WIDTH(QUES_WIDTH)) u_ques ( // see RULE_09
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .event_i(ques_event_i),
    .enable_i(ques_enable_i),
    .summary_o(questionable_summary)
  ); // see RULE_02

  mask_summary #(.WIDTH(OPER_WIDTH)) u_oper (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .event_i(oper_event_i),
    .enable_i(oper_enable_i),
    .summary_o(operation_summary)
  ); // see RULE_06 see RULE_12

  mask_summary #(.WIDTH(STD_WIDTH)) u_std (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .event_i(std_event_i),
    .enable_i(std_enable_i),
    .summary_o(evt_summary)
  ); // see RULE_04

  // ----------------------------------------
  // Service request decode
  // ----------------------------------------
  // Bit 6 is the result, so it can never be one of its own causes
  function automatic logic any_service_reason(
    input logic [7:0] status_bits,
    input logic [7:0] enable_bits
  );
    logic [7:0] cause_mask;
    cause_mask = ~(8'h01 << BIT_MASTER);
    return |(status_bits & enable_bits & cause_mask);
  endfunction : any_service_reason

  // ----------------------------------------
  // Summary byte assembly
  // ----------------------------------------
  logic err_d;
  logic err_q;
  logic mav_d;
  logic mav_q;
  logic [7:0] stb_d;
  logic [7:0] stb_q;
  logic mss_d;
  logic mss_q;

  // Queue levels registered to match the summary latency
  always_comb begin
    err_d = err_queue_nonempty_i; // see RULE_01
    mav_d = out_queue_nonempty_i; // see RULE_03
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      err_q <= 1'b0;
      mav_q <= 1'b0;
    end else begin
      err_q <= err_d;
      mav_q <= mav_d;
    end
  end

  always_comb begin
    stb_d = STB_RESET;
    stb_d[BIT_RSVD0] = 1'b0; // see RULE_14
    stb_d[BIT_RSVD1] = 1'b0; // see RULE_14
    stb_d[BIT_ERRQ] = err_q; // see RULE_01
    stb_d[BIT_QUES] = questionable_summary; // see RULE_02
    stb_d[BIT_MSG_AVAIL] = mav_q; // see RULE_03
    stb_d[BIT_EVT_SUM] = evt_summary; // see RULE_04
    stb_d[BIT_OPER] = operation_summary; // see RULE_06
    // Reserved bits already zero, so they add no cause
    mss_d = any_service_reason(stb_d, srq_enable_i); // see RULE_11 see RULE_05
    stb_d[BIT_MASTER] = mss_d; // see RULE_05
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stb_q <= STB_RESET;
      mss_q <= 1'b0;
    end else begin
      stb_q <= stb_d;
      mss_q <= mss_d;
    end
  end

  // ----------------------------------------
  // Read paths: serial poll and status query
  // ----------------------------------------
  logic reply_valid_d;
  logic reply_valid_q;
  logic [7:0] reply_data_d;
  logic [7:0] reply_data_q;
  logic reply_is_query_d;
  logic reply_is_query_q;

  // Query wins if both arrive together; neither clears state
  always_comb begin
    reply_valid_d = poll_req_i | query_req_i; // see RULE_07
    reply_data_d = reply_data_q;
    reply_is_query_d = reply_is_query_q;
    if (query_req_i) begin
      reply_data_d = stb_q; // see RULE_08 see RULE_13
      reply_is_query_d = 1'b1;
    end else if (poll_req_i) begin
      // RQS not implemented, so poll shows the same byte
      reply_data_d = stb_q; // see RULE_07
      reply_is_query_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reply_valid_q <= 1'b0;
      reply_data_q <= STB_RESET;
      reply_is_query_q <= 1'b0;
    end else begin
      reply_valid_q <= reply_valid_d;
      reply_data_q <= reply_data_d;
      reply_is_query_q <= reply_is_query_d;
    end
  end

  // ----------------------------------------
  // Outputs, all straight from registers
  // ----------------------------------------
  assign status_summary_byte_o = stb_q;
  assign master_summary_o = mss_q;
  assign reply_valid_o = reply_valid_q;
  assign reply_data_o = reply_data_q;
  assign reply_is_query_o = reply_is_query_q;

endmodule : status_byte_summary

// file: status_byte_monitor.sv
// Purpose: Port checker for the status summary byte
// Assumes: Bound to the design top with its widths
// Notes: Waits one or two edges after reset so $past has history
`timescale 1ns/1ps
module status_byte_monitor #(parameter int unsigned QUES_WIDTH = 16, OPER_WIDTH = 16, STD_WIDTH = 8) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic err_queue_nonempty_i,
  input wire logic out_queue_nonempty_i,
  input wire logic [QUES_WIDTH-1:0] ques_event_i,
  input wire logic [QUES_WIDTH-1:0] ques_enable_i,
  input wire logic [OPER_WIDTH-1:0] oper_event_i,
  input wire logic [OPER_WIDTH-1:0] oper_enable_i,
  input wire logic [STD_WIDTH-1:0] std_event_i,
  input wire logic [STD_WIDTH-1:0] std_enable_i,
  input wire logic [7:0] srq_enable_i,
  input wire logic poll_req_i,
  input wire logic query_req_i,
  input wire logic [7:0] status_summary_byte_o,
  input wire logic master_summary_o,
  input wire logic reply_valid_o,
  input wire logic [7:0] reply_data_o,
  input wire logic reply_is_query_o
);
  wire logic [7:0] sb = status_summary_byte_o;
  wire logic err = err_queue_nonempty_i;
  wire logic mav = out_queue_nonempty_i;
  wire logic req = poll_req_i | query_req_i;
  wire logic q_hit = |(ques_event_i & ques_enable_i);
  wire logic o_hit = |(oper_event_i & oper_enable_i);
  wire logic s_hit = |(std_event_i & std_enable_i);
  logic [1:0] up_q;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) up_q <= 2'h0;
    else if (!up_q[1]) up_q <= up_q + 2'h1;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  rsvd_zero_a: assert property (sb[1:0] == 2'h0) else $error("reserved bits set");
  err_ques_a: assert property (up_q[1] |-> sb[3:2] == {$past(q_hit, 2), $past(err, 2)})
    else $error("bits 3:2 wrong");
  mav_esb_a: assert property (up_q[1] |-> sb[5:4] == {$past(s_hit, 2), $past(mav, 2)})
    else $error("bits 5:4 wrong");
  oper_bit_a: assert property (up_q[1] |-> sb[7] == $past(o_hit, 2)) else $error("bit 7 wrong");
  mss_copy_a: assert property (master_summary_o == sb[6]) else $error("master differs");
  mss_calc_a: assert property (up_q[1] |-> sb[6] == |(sb & $past(srq_enable_i) & 8'hBF))
    else $error("master wrong");
  reply_pulse_a: assert property (|up_q |-> reply_valid_o == $past(req)) else $error("reply strobe wrong");
  reply_data_a: assert property (|up_q && reply_valid_o |-> reply_data_o == $past(sb)
    && reply_is_query_o == $past(query_req_i)) else $error("reply wrong");
  cover property (reply_valid_o && reply_is_query_o);
  cover property (reply_valid_o && !reply_is_query_o);
  cover property (master_summary_o && sb[7]);
endmodule : status_byte_monitor
bind status_byte_summary status_byte_monitor #(.QUES_WIDTH(QUES_WIDTH), .OPER_WIDTH(OPER_WIDTH),
  .STD_WIDTH(STD_WIDTH)) i_status_byte_monitor (.*);

// file: host_poller.sv
// Purpose: Remote host model issuing status reads
// Assumes: Commands change just after a rising edge
// Notes: Poll and query may be raised together
`timescale 1ns/1ps
module host_poller (
  input wire logic [1:0] cmd_i,
  output logic poll_req_o,
  output logic query_req_o
);
  assign poll_req_o = cmd_i[0];
  assign query_req_o = cmd_i[1];
endmodule : host_poller

// file: testbench.sv
// Purpose: Self-checking bench for the status summary byte
// Assumes: Byte two edges behind sources, enable and reply one edge
// Notes: Sparse events so every summary toggles
`timescale 1ns/1ps
module testbench;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic err_queue_nonempty_i, out_queue_nonempty_i, poll_req_i, query_req_i, e, o;
  logic master_summary_o, reply_valid_o, reply_is_query_o;
  logic [15:0] ques_event_i, ques_enable_i, oper_event_i, oper_enable_i, qe, qm, oe, om;
  logic [7:0] std_event_i, std_enable_i, srq_enable_i, status_summary_byte_o, reply_data_o, b, se, sm, sr;
  logic [7:0] b2, s1, x, xp;
  logic [1:0] c, pc, k1;
  logic [7:0] bq [$];
  logic [7:0] sq [$];
  logic [1:0] cq [$];
  int fail_count = 0;
  int checks_done = 0;
  status_byte_summary i_status_byte_summary (.*);
  host_poller i_host_poller (.cmd_i(pc), .poll_req_o(poll_req_i), .query_req_o(query_req_i));
  always #4 sys_clk_i = ~sys_clk_i;
  function automatic logic [15:0] r();
    return 16'($urandom & $urandom & $urandom);
  endfunction : r
  task chk(input logic [7:0] g, input logic [7:0] x);
    checks_done++;
    if (g !== x) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  task end_sim();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  initial begin
    #20000;
    fail_count++;
    end_sim();
  end
  initial begin
    void'($urandom(32'h3C8C));
    {err_queue_nonempty_i, out_queue_nonempty_i, ques_event_i, ques_enable_i, oper_event_i} = '0;
    {oper_enable_i, std_event_i, std_enable_i, srq_enable_i, pc} = '0;
    repeat (6) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    for (int j = 0; j < 400; j++) begin
      @(posedge sys_clk_i);
      {qe, qm, oe, om} = {r(), r(), r(), r()};
      {se, sm, sr, e, o, c} = {r(), 8'($urandom), 4'($urandom)};
      {err_queue_nonempty_i, out_queue_nonempty_i, ques_event_i, ques_enable_i} <= {e, o, qe, qm};
      {oper_event_i, oper_enable_i, std_event_i, std_enable_i, srq_enable_i, pc} <= {oe, om, se, sm, sr, c};
      b = {|(oe & om), 1'b0, |(se & sm), o, |(qe & qm), e, 2'h0};
      bq.push_back(b);
      sq.push_back(sr);
      cq.push_back(c);
      @(negedge sys_clk_i);
      if (j > 0) begin
        s1 = sq.pop_front();
        k1 = cq.pop_front();
      end
      if (j > 1) begin
        b2 = bq.pop_front();
        xp = x;
        // Enable reaches bit 6 one edge sooner than the sources reach their bits
        x = {b2[7], |(b2 & s1), b2[5:0]};
        chk(status_summary_byte_o, x);
        chk({7'h0, master_summary_o}, {7'h0, x[6]});
      end
      if (j > 2) begin
        chk({6'h0, reply_valid_o, reply_valid_o & reply_is_query_o}, {6'h0, |k1, k1[1]});
        if (|k1) chk(reply_data_o, xp);
      end
    end
    $display("random poll and query test done");
    // Mid-run reset with both queues busy and every service enable bit set
    @(posedge sys_clk_i);
    resetn_i <= 1'b0;
    {err_queue_nonempty_i, out_queue_nonempty_i, srq_enable_i, pc} <= {2'h3, 8'hFF, 2'h0};
    {ques_event_i, oper_event_i, std_event_i} <= '0;
    @(negedge sys_clk_i);
    chk(status_summary_byte_o, 8'h00);
    chk({5'h0, master_summary_o, reply_valid_o, reply_is_query_o}, 8'h00);
    chk(reply_data_o, 8'h00);
    repeat (2) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk(status_summary_byte_o, 8'h00);
    @(negedge sys_clk_i);
    chk(status_summary_byte_o, 8'h54);
    chk({7'h0, master_summary_o}, 8'h01);
    $display("mid-run reset test done");
    end_sim();
  end
endmodule : testbench
